//--- temp_flags_pkg.sv
// Shared constants and types for the temperature status-flag block
package temp_flags_pkg;

    localparam int CH_COUNT = 6;

    // Bus slave addresses of the four device variants
    localparam logic [6:0] SLAVE_ADDR_0 = 7'h1A;
    localparam logic [6:0] SLAVE_ADDR_1 = 7'h1C;
    localparam logic [6:0] SLAVE_ADDR_2 = 7'h4C;
    localparam logic [6:0] SLAVE_ADDR_3 = 7'h4E;

    // Command bytes selecting the status registers
    localparam logic [7:0] CMD_OVERTEMP_STATUS = 8'h43;
    localparam logic [7:0] CMD_FAULT_STATUS = 8'h44;

    // Reset values of the two status registers
    localparam logic [7:0] OVERTEMP_STATUS_RESET = 8'h00;
    localparam logic [7:0] DIODE_FAULT_STATUS_RESET = 8'h00;

    // Channels with an overtemperature limit: 1, 4, 5 and 6 (bits 0, 3, 4, 5)
    localparam logic [5:0] OT_CHANNELS = 6'h39;
    // Reserved bits of each status register
    localparam logic [7:0] OVERTEMP_RESERVED = 8'hC6;
    localparam logic [7:0] FAULT_RESERVED = 8'h81;
    // Fault bit of channel N sits at position N
    localparam int FAULT_LSB = 1;

    // Clock cycles spent on each channel of the measurement sequence
    localparam int CONV_CYCLES_DEFAULT = 1024;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ACK_ADDR,
        BUS_CMD,
        BUS_ACK_CMD,
        BUS_WAIT_RESTART,
        BUS_SEND,
        BUS_HOST_ACK
    } bus_state_t;

    // Measured temperature and overtemperature limit per remote channel
    typedef struct packed {
        logic [5:0][7:0] temp;
        logic [5:0][7:0] limit;
    } readings_t;

    // Complete state of the block
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_q;
        logic sda_s1;
        logic sda_s2;
        logic sda_q;
        logic [5:0] short_s1;
        logic [5:0] short_s2;
        logic [5:0] open_s1;
        logic [5:0] open_s2;
        bus_state_t bus_state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic rw;
        logic [7:0] cmd;
        logic sda_hold;
        logic [5:0] ot_flags;
        logic [5:0] fault_flags;
        logic ot_pin;
        logic [2:0] ch_ptr;
        logic [15:0] timer;
    } core_state_t;

endpackage

//--- temp_status_flags.sv
// Status flags, channel scan and two-wire read-byte slave of the temperature monitor
// Functional notes
// R1: Channel 1/4/5/6 overtemp flag sets at status bits 0/3/4/5 when temp exceeds limit.
// R2: Channel N diode fault shows at bit N when pin pair is shorted or open.
// R3: Both status registers, reserved bits too, read zero after reset.
// R4: Device answers only its one fixed 7-bit slave address; host must use it.
// R5: A shorted channel is flagged faulty and skipped by the measurement sequence; if all six are shorted the scan stays on its current channel.
// R6: A mask bit set to one keeps that channel from asserting the overtemp output.
// R7: Host reads status with read-byte: address, command byte, restart, address, data.
`timescale 1ns/1ps
module temp_status_flags
    import temp_flags_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_2,
    parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b_out,
    input wire logic [5:0] sense_pair_short_in,
    input wire logic [5:0] sense_pair_open_in,
    input wire readings_t readings_in,
    input wire logic [5:0] overtemp_mask_in,
    output logic [7:0] overtemp_status_out,
    output logic [7:0] diode_fault_status_out,
    output logic overtemp_output_oe_b_out,
    output logic [2:0] scan_channel_out
);

    localparam core_state_t STATE_RESET = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1,
        bus_state: BUS_IDLE, default: '0
    };

    core_state_t q;
    core_state_t next_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [5:0] fault_now;
    logic [7:0] ot_status;
    logic [7:0] fault_status;
    logic [7:0] read_value;

    // Next channel after cur that is not shorted; stays put if all are shorted
    function automatic logic [2:0] next_channel(input logic [2:0] cur, input logic [5:0] skip);
        logic [2:0] n;
        logic found;
        int idx;
        n = cur;
        found = 1'b0;
        idx = 0;
        for (int i = 1; i <= CH_COUNT; i++) begin
            idx = (int'(cur) + i) % CH_COUNT;
            if (!found && !skip[idx]) begin
                n = 3'(idx);
                found = 1'b1;
            end
        end
        return n;
    endfunction

    // Register selected by the command byte; unknown commands read zero
    function automatic logic [7:0] read_mux(input logic [7:0] cmd, input logic [7:0] ot,
                                            input logic [7:0] fault);
        if (cmd == CMD_OVERTEMP_STATUS) begin
            return ot;
        end else if (cmd == CMD_FAULT_STATUS) begin
            return fault;
        end else begin
            return 8'h00;
        end
    endfunction

    // Status images; reserved positions are hard zero
    assign ot_status = {2'b00, q.ot_flags & OT_CHANNELS} & ~OVERTEMP_RESERVED; // R1 R3
    assign fault_status = {1'b0, q.fault_flags, 1'b0} & ~FAULT_RESERVED; // R2 R3
    // Byte offered to the host; its top bit goes out first
    assign read_value = read_mux(q.cmd, ot_status, fault_status); // R7

    // Bus events from synchronised pins only
    assign scl_rise = q.scl_s2 & ~q.scl_q;
    assign scl_fall = ~q.scl_s2 & q.scl_q;
    assign bus_start = q.scl_s2 & q.scl_q & q.sda_q & ~q.sda_s2;
    assign bus_stop = q.scl_s2 & q.scl_q & ~q.sda_q & q.sda_s2;
    assign fault_now = q.short_s2 | q.open_s2;

    always_comb begin
        next_q = q;
        // Two-flop synchronisers for the bus pins and the pin-pair detectors; readings and mask are used unsynchronised
        next_q.scl_s1 = scl_in;
        next_q.scl_s2 = q.scl_s1;
        next_q.scl_q = q.scl_s2;
        next_q.sda_s1 = sda_in;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_q = q.sda_s2;
        next_q.short_s1 = sense_pair_short_in;
        next_q.short_s2 = q.short_s1;
        next_q.open_s1 = sense_pair_open_in;
        next_q.open_s2 = q.open_s1;

        // Fault bits follow the pin-pair detectors, even for skipped channels
        next_q.fault_flags = fault_now; // R2 R5

        // Scan: one slot per channel, shorted channels get no slot unless all six are shorted
        if (q.timer == 16'h0000) begin
            next_q.timer = 16'(CONV_CYCLES - 1);
            if (OT_CHANNELS[q.ch_ptr] && !fault_now[q.ch_ptr]) begin
                next_q.ot_flags[q.ch_ptr] = readings_in.temp[q.ch_ptr] > readings_in.limit[q.ch_ptr]; // R1
            end
            next_q.ch_ptr = next_channel(q.ch_ptr, q.short_s2); // R5
        end else begin
            next_q.timer = q.timer - 16'h0001;
        end

        // Open-drain overtemp pin, masked per channel
        next_q.ot_pin = |(q.ot_flags & OT_CHANNELS & ~overtemp_mask_in); // R6

        // Two-wire slave; stop and start override any state
        if (bus_stop) begin
            next_q.bus_state = BUS_IDLE;
            next_q.sda_hold = 1'b0;
        end else if (bus_start) begin
            next_q.bus_state = BUS_ADDR;
            next_q.bit_cnt = 4'h0;
            next_q.sda_hold = 1'b0;
        end else begin
            case (q.bus_state)
                BUS_ADDR, BUS_CMD: begin
                    if (scl_rise && q.bit_cnt < 4'h8) begin
                        next_q.shift = {q.shift[6:0], q.sda_s2};
                        next_q.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall && q.bit_cnt == 4'h8) begin
                        if (q.bus_state == BUS_CMD) begin
                            next_q.cmd = q.shift; // R7
                            next_q.sda_hold = 1'b1;
                            next_q.bus_state = BUS_ACK_CMD;
                        end else if (q.shift[7:1] == SLAVE_ADDR) begin
                            next_q.rw = q.shift[0]; // R4
                            next_q.sda_hold = 1'b1;
                            next_q.bus_state = BUS_ACK_ADDR;
                        end else begin
                            next_q.bus_state = BUS_IDLE; // R4
                        end
                    end
                end
                BUS_ACK_ADDR: begin
                    if (scl_fall && q.rw) begin
                        next_q.shift = read_value; // R7
                        next_q.sda_hold = ~read_value[7];
                        next_q.bit_cnt = 4'h1;
                        next_q.bus_state = BUS_SEND;
                    end else if (scl_fall) begin
                        next_q.sda_hold = 1'b0;
                        next_q.bit_cnt = 4'h0;
                        next_q.bus_state = BUS_CMD;
                    end
                end
                BUS_ACK_CMD: begin
                    // Write data after the command is not taken; wait for restart
                    if (scl_fall) begin
                        next_q.sda_hold = 1'b0;
                        next_q.bus_state = BUS_WAIT_RESTART;
                    end
                end
                BUS_SEND: begin
                    // Data changes only while the clock is low
                    if (scl_fall && q.bit_cnt == 4'h8) begin
                        next_q.sda_hold = 1'b0;
                        next_q.bus_state = BUS_HOST_ACK;
                    end else if (scl_fall) begin
                        next_q.sda_hold = ~q.shift[6];
                        next_q.shift = {q.shift[6:0], 1'b0};
                        next_q.bit_cnt = q.bit_cnt + 4'h1;
                    end
                end
                BUS_HOST_ACK: begin
                    // One byte per read-byte transfer, acknowledged or not
                    if (scl_rise) begin
                        next_q.bus_state = BUS_IDLE;
                    end
                end
                default: begin
                    next_q.bus_state = q.bus_state;
                end
            endcase
        end
    end

    // Single state register; reset clears all status
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            q <= STATE_RESET; // R3
        end else begin
            q <= next_q;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_b_out = ~q.sda_hold;
    assign overtemp_output_oe_b_out = ~q.ot_pin;
    assign overtemp_status_out = ot_status;
    assign diode_fault_status_out = fault_status;
    assign scan_channel_out = q.ch_ptr;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_ot_update;
        (q.timer == 16'h0000 && OT_CHANNELS[q.ch_ptr] && !fault_now[q.ch_ptr])
            |=> q.ot_flags[$past(q.ch_ptr)] == ($past(readings_in.temp[q.ch_ptr]) > $past(readings_in.limit[q.ch_ptr]));
    endproperty
    a_ot_update: assert property (p_ot_update) else $error("overtemp flag not updated from compare"); // R1

    property p_fault_bits;
        ##1 diode_fault_status_out[6:1] == $past(q.short_s2 | q.open_s2);
    endproperty
    a_fault_bits: assert property (p_fault_bits) else $error("fault bits do not follow detectors"); // R2

    property p_reset_clear;
        disable iff (1'b0) $past(!rst_b_in) |-> overtemp_status_out == OVERTEMP_STATUS_RESET
            && diode_fault_status_out == DIODE_FAULT_STATUS_RESET && overtemp_output_oe_b_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("status not clear after reset"); // R3

    property p_reserved_zero;
        (overtemp_status_out & OVERTEMP_RESERVED) == 8'h00 && (diode_fault_status_out & FAULT_RESERVED) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set"); // R3

    property p_addr_ack;
        $rose(q.bus_state == BUS_ACK_ADDR) |-> q.shift[7:1] == SLAVE_ADDR ##1 !sda_oe_b_out;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("acknowledged a foreign address"); // R4

    property p_skip_shorted;
        (q.timer == 16'h0000 && q.short_s2 != 6'h3F) |=> ($past(q.short_s2) & (6'h01 << q.ch_ptr)) == 6'h00;
    endproperty
    a_skip_shorted: assert property (p_skip_shorted) else $error("scan landed on shorted channel"); // R5

    property p_mask;
        ##1 overtemp_output_oe_b_out == !$past(|(q.ot_flags & OT_CHANNELS & ~overtemp_mask_in));
    endproperty
    a_mask: assert property (p_mask) else $error("overtemp pin ignores mask"); // R6

    property p_read_data;
        $rose(q.bus_state == BUS_SEND) |-> q.shift == read_mux(q.cmd, $past(ot_status), $past(fault_status))
            && sda_oe_b_out == q.shift[7];
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not from selected register"); // R7

    c_read: cover property ($rose(q.bus_state == BUS_SEND));
    c_overtemp_pin: cover property ($fell(overtemp_output_oe_b_out));
    c_skip: cover property (q.timer == 16'h0000 && q.short_s2 != 6'h00);

endmodule

//--- smbus_host_model.sv
// Two-wire bus host model that issues read-byte transfers
`timescale 1ns/1ps
module smbus_host_model (
    input wire logic clk_in,
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_oe_b_out
);
    // Idle bus: both lines released
    initial begin
        scl_out = 1'b1;
        sda_oe_b_out = 1'b1;
    end
    // Pins move on falling edges, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // One bit; 8 clk phases keep the 5 clk minimum with margin
    task automatic pulse(input logic b, output logic seen);
        tick(4);
        sda_oe_b_out = b;
        tick(4);
        scl_out = 1'b1;
        tick(8);
        seen = sda_line_in;
        scl_out = 1'b0;
    endtask
    // Start, or repeated start when the clock is low
    task automatic start_cond();
        if (!scl_out) begin
            tick(4);
            sda_oe_b_out = 1'b1;
            tick(4);
            scl_out = 1'b1;
        end
        tick(8);
        sda_oe_b_out = 1'b0;
        tick(8);
        scl_out = 1'b0;
    endtask
    task automatic stop_cond();
        tick(4);
        sda_oe_b_out = 1'b0;
        tick(4);
        scl_out = 1'b1;
        tick(8);
        sda_oe_b_out = 1'b1;
        tick(8);
    endtask
    task automatic send_byte(input logic [7:0] v, output logic acked);
        logic seen;
        for (int i = 7; i >= 0; i--) pulse(v[i], seen);
        pulse(1'b1, seen);
        acked = !seen;
    endtask
    // Full read-byte; a refused write address ends the transfer at once
    task automatic read_byte(input logic [6:0] addr, input logic [7:0] cmd, output logic [7:0] data,
                             output logic acked);
        logic a2;
        logic seen;
        data = 8'h00;
        start_cond();
        send_byte({addr, 1'b0}, acked);
        if (acked) begin
            send_byte(cmd, a2);
            acked = acked & a2;
            start_cond();
            send_byte({addr, 1'b1}, a2);
            acked = acked & a2;
            for (int i = 7; i >= 0; i--) pulse(1'b1, data[i]);
            pulse(1'b1, seen);
        end
        stop_cond();
    endtask
endmodule

//--- temp_status_flags_tb.sv
// Self-checking bench for the temperature status-flag block
`timescale 1ns/1ps
module temp_status_flags_tb
    import temp_flags_pkg::*;
;
    logic clk_in;
    logic rst_b_in;
    logic scl;
    logic host_oe_b;
    logic sda_out;
    logic sda_oe_b_out;
    logic sda_line;
    logic [5:0] short_in;
    logic [5:0] open_in;
    readings_t readings;
    logic [5:0] mask;
    logic [7:0] ot_status;
    logic [7:0] fault_status;
    logic ot_pin_b;
    logic [2:0] scan_ch;
    logic [31:0] seed;
    logic [6:0] addrs [4];
    int ot_exp [6];
    int mismatches;
    int samples_checked;

    // Pull-up on the data line: low if either party pulls
    assign sda_line = host_oe_b & (sda_oe_b_out | sda_out);

    temp_status_flags #(.SLAVE_ADDR(SLAVE_ADDR_2), .CONV_CYCLES(4)) dut (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out),
        .sense_pair_short_in(short_in), .sense_pair_open_in(open_in),
        .readings_in(readings), .overtemp_mask_in(mask),
        .overtemp_status_out(ot_status), .diode_fault_status_out(fault_status),
        .overtemp_output_oe_b_out(ot_pin_b), .scan_channel_out(scan_ch));

    smbus_host_model host (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_oe_b_out(host_oe_b));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reads one register and compares data and acknowledge
    task automatic bus_read(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] rd;
        logic ack;
        host.read_byte(SLAVE_ADDR_2, cmd, rd, ack);
        check8({7'h00, ack}, 8'h01);
        check8(rd, exp);
    endtask

    // Random faults settle first, so the fresh readings meet a stable fault set
    task automatic run_round();
        logic [31:0] r;
        logic [5:0] fl;
        logic [7:0] ft;
        r = next_rand();
        short_in = r[5:0] & r[11:6];
        if (&short_in) short_in[0] = 1'b0;
        open_in = r[17:12] & r[23:18];
        mask = r[29:24];
        repeat (20) @(negedge clk_in);
        readings = {next_rand(), next_rand(), next_rand()};
        // A shorted channel never holds the scan slot
        repeat (100) begin
            @(negedge clk_in);
            check8({7'h00, short_in[scan_ch]}, 8'h00);
        end
        // Faulted channels keep their previous flag
        for (int k = 0; k < CH_COUNT; k++) begin
            if (OT_CHANNELS[k] && !(short_in[k] | open_in[k])) ot_exp[k] = int'(readings.temp[k] > readings.limit[k]);
            fl[k] = OT_CHANNELS[k] && ot_exp[k] != 0;
        end
        ft = {1'b0, short_in | open_in, 1'b0};
        check8(ot_status, {2'b00, fl});
        check8(fault_status, ft);
        check8({7'h00, ot_pin_b}, {7'h00, ~|(fl & ~mask)});
        bus_read(CMD_OVERTEMP_STATUS, {2'b00, fl});
        bus_read(CMD_FAULT_STATUS, ft);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_in);
        mismatches++;
        close_out();
    end

    initial begin
        logic [7:0] rd;
        logic ack;
        rst_b_in = 1'b0;
        short_in = 6'h00;
        open_in = 6'h00;
        readings = '0;
        mask = 6'h00;
        seed = 32'h0000_B23C;
        mismatches = 0;
        samples_checked = 0;
        ot_exp = '{default: 0};
        addrs = '{SLAVE_ADDR_0, SLAVE_ADDR_1, SLAVE_ADDR_2, SLAVE_ADDR_3};
        repeat (12) @(negedge clk_in);
        rst_b_in = 1'b1;
        check8(ot_status, OVERTEMP_STATUS_RESET);
        check8(fault_status, DIODE_FAULT_STATUS_RESET);
        bus_read(CMD_OVERTEMP_STATUS, 8'h00);
        bus_read(CMD_FAULT_STATUS, 8'h00);
        // Only the fitted variant address is acknowledged
        for (int a = 0; a < 4; a++) begin
            host.read_byte(addrs[a], CMD_FAULT_STATUS, rd, ack);
            check8({7'h00, ack}, {7'h00, addrs[a] == SLAVE_ADDR_2});
        end
        bus_read(8'h45, 8'h00);
        repeat (12) run_round();
        // Reset in mid-run with faults still present
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_in);
        check8(ot_status, 8'h00);
        check8(fault_status, 8'h00);
        check8({7'h00, ot_pin_b}, 8'h01);
        ot_exp = '{default: 0};
        repeat (10) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (3) run_round();
        close_out();
    end
endmodule
